/* fes_pkg.sv */
// Shared types and constants for the floating-point error signalling block.
// Assumes one 10 MHz clock and an asynchronous active-low reset.
//
// What this block does
// - mode bit one internal, zero external
// - internal mode raises vector 16, pins idle
// - compat mode reports on error output, honours ignore
// - deferred error freezes before next wait/fp
// - no-wait instructions never freeze
// - freeze always asserts the error output
// - frozen core waits for external interrupt
// - arithmetic, precision-only, transcendental overflow/underflow/zero-divide use deferred
// - other store and transcendental faults report immediately
// - immediate uncleared error also freezes later
// - active ignore keeps error output deasserted
// - ignore release resumes normal reporting
// - ignore blocks freeze even after interrupt
// - software clear deasserts the error output
package fes_pkg;

	// trap vector raised in internal reporting mode
	localparam logic [7:0] FES_NATIVE_VECTOR = 8'h10;
	// mode bit value that selects internal reporting
	localparam logic FES_MODE_NATIVE = 1'h1;
	// reset values of the pin-facing state
	localparam logic FES_ERR_N_RESET = 1'h1;
	localparam logic FES_FLAG_RESET = 1'h0;

	// class of the instruction that raised an exception
	typedef enum logic [1:0] {
		FES_XC_ARITH = 2'b00,
		FES_XC_TRANSC = 2'b01,
		FES_XC_STORE = 2'b10,
		FES_XC_OTHER = 2'b11
	} fes_xclass_t;

	// kind of instruction about to issue
	typedef enum logic [1:0] {
		FES_IS_NONE = 2'b00,
		FES_IS_WAIT_FP = 2'b01,
		FES_IS_NO_WAIT = 2'b10,
		FES_IS_PLAIN = 2'b11
	} fes_issue_kind_t;

	// exception report from the arithmetic core, valid for one cycle
	typedef struct packed {
		logic valid;
		logic unmasked;
		fes_xclass_t cls;
		logic precision;
		logic overflow;
		logic underflow;
		logic stack_fault;
		logic invalid;
		logic denormal;
		logic zero_divide;
	} fes_exc_t;

	// whole state of the signalling block
	typedef struct packed {
		logic ign_s1;
		logic ign_s2;
		logic pend;
		logic imm;
		logic err_n;
		logic frozen;
		logic brief;
		logic trap16;
	} fes_state_t;

	// immediate reporting: non-precision store faults, and stack/invalid/denormal
	// from transcendental-like ops; everything else waits for the next fp op
	function automatic logic fes_is_immediate(input fes_exc_t e);
		logic r;
		r = 1'b0;
		if (e.cls == FES_XC_STORE)
			r = e.stack_fault | e.invalid | e.denormal | e.overflow
				| e.underflow | e.zero_divide;
		else if (e.cls == FES_XC_TRANSC)
			r = e.stack_fault | e.invalid | e.denormal;
		return r;
	endfunction : fes_is_immediate

endpackage : fes_pkg

/* fes_error_signal.sv */
// Floating-point error signalling: internal trap or external error/ignore pins.
// Assumes the ignore pin is asynchronous; all other inputs come from core logic
// on ref_clk. Outside latch and interrupt controller are not part of this block.
`timescale 1ns/1ps
module fes_error_signal
	import fes_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic native_error_mode_select,
	input wire fes_exc_t exc_in,
	input wire fes_issue_kind_t issue_kind,
	input wire logic clear_exception,
	input wire logic maskable_interrupt_in_taken,
	input wire logic ignore_numeric_error_n,
	output logic fp_error_out_n,
	output logic freeze_hold,
	output logic trap16_req
);

	////////////////////////////////////////////////////////////////////////////
	// state

	fes_state_t st_reg;
	fes_state_t st_next;
	logic ign;
	logic exc_hit;
	logic compat;

	assign ign = st_reg.ign_s2;
	assign exc_hit = exc_in.valid & exc_in.unmasked;
	assign compat = (native_error_mode_select != FES_MODE_NATIVE);

	////////////////////////////////////////////////////////////////////////////
	// next-state logic

	// one pass over the whole state; later assignments take priority
	always_comb
	begin
		st_next = st_reg;
		st_next.ign_s1 = ~ignore_numeric_error_n;
		st_next.ign_s2 = st_reg.ign_s1;
		st_next.trap16 = 1'b0;
		st_next.brief = 1'b0;
		// a no-wait assertion lasts one cycle only
		if (st_reg.brief)
			st_next.err_n = 1'b1;
		// clear first so that a new exception in the same cycle still wins
		if (clear_exception)
		begin
			st_next.pend = 1'b0;
			st_next.frozen = 1'b0;
			st_next.err_n = 1'b1;
		end
		if (exc_hit)
		begin
			st_next.pend = 1'b1;
			st_next.imm = fes_is_immediate(exc_in);
		end
		if (compat)
		begin
			// immediate cases report at once, or as soon as ignore lets go
			if (st_next.pend && st_next.imm && !ign)
				st_next.err_n = 1'b0;
			// ignore suppresses the freeze even with the error already out
			if (issue_kind == FES_IS_WAIT_FP && st_reg.pend && !ign && !clear_exception)
			begin
				st_next.frozen = 1'b1;
				st_next.err_n = 1'b0;
			end
			// no-wait ops pulse the error briefly but keep running
			if (issue_kind == FES_IS_NO_WAIT && st_reg.pend && !ign && st_reg.err_n
				&& !clear_exception)
			begin
				st_next.err_n = 1'b0;
				st_next.brief = 1'b1;
			end
			// the external interrupt releases the freeze into the handler
			if (st_reg.frozen && maskable_interrupt_in_taken)
				st_next.frozen = 1'b0;
		end
		else
		begin
			// internal mode: pins stay idle, the trap is raised at the next fp op
			st_next.err_n = 1'b1;
			st_next.frozen = 1'b0;
			if (issue_kind == FES_IS_WAIT_FP && st_reg.pend && !clear_exception)
				st_next.trap16 = 1'b1;
		end
	end

	// register the whole state; reset leaves every pin inactive
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			st_reg <= '0;
			st_reg.err_n <= FES_ERR_N_RESET;
			st_reg.frozen <= FES_FLAG_RESET;
		end
		else
			st_reg <= st_next;
	end

	assign fp_error_out_n = st_reg.err_n;
	assign freeze_hold = st_reg.frozen;
	assign trap16_req = st_reg.trap16;

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence s_native_two;
		native_error_mode_select [*2];
	endsequence

	sequence s_wait_pending;
		compat && issue_kind == FES_IS_WAIT_FP && st_reg.pend && !ign && !clear_exception
			&& !(st_reg.frozen && maskable_interrupt_in_taken);
	endsequence

	// pin held low for two samples
	sequence s_pin_low_two;
		!ignore_numeric_error_n ##1 !ignore_numeric_error_n;
	endsequence

	// pin held high for two samples
	sequence s_pin_high_two;
		ignore_numeric_error_n ##1 ignore_numeric_error_n;
	endsequence

	sequence s_nowait_pulse;
		compat && issue_kind == FES_IS_NO_WAIT && st_reg.pend && !ign && st_reg.err_n
			&& !clear_exception && !exc_hit;
	endsequence

	property p_native_idle;
		@(posedge ref_clk) disable iff (!rst_b)
		s_native_two |-> fp_error_out_n && !freeze_hold;
	endproperty
	a_native_idle: assert property (p_native_idle)
		else $error("error pins active in native mode");

	property p_native_trap;
		@(posedge ref_clk) disable iff (!rst_b)
		!compat && issue_kind == FES_IS_WAIT_FP && st_reg.pend && !clear_exception
			|=> trap16_req;
	endproperty
	a_native_trap: assert property (p_native_trap)
		else $error("native trap not raised for one cycle");

	property p_freeze;
		@(posedge ref_clk) disable iff (!rst_b)
		s_wait_pending |=> freeze_hold && !fp_error_out_n;
	endproperty
	a_freeze: assert property (p_freeze)
		else $error("freeze without error output");

	property p_immediate;
		@(posedge ref_clk) disable iff (!rst_b)
		compat && exc_hit && fes_is_immediate(exc_in) && !ign |=> !fp_error_out_n;
	endproperty
	a_immediate: assert property (p_immediate)
		else $error("immediate error not reported");

	property p_deferred;
		@(posedge ref_clk) disable iff (!rst_b)
		compat && exc_hit && !fes_is_immediate(exc_in) && !st_reg.pend && st_reg.err_n
			&& issue_kind == FES_IS_NONE |=> fp_error_out_n && !freeze_hold;
	endproperty
	a_deferred: assert property (p_deferred)
		else $error("deferred error reported early");

	property p_nowait;
		@(posedge ref_clk) disable iff (!rst_b)
		s_nowait_pulse ##0 !st_reg.frozen && !st_reg.imm
			|=> !fp_error_out_n && !freeze_hold
			##1 (fp_error_out_n || $past(issue_kind) == FES_IS_WAIT_FP || $past(exc_hit));
	endproperty
	a_nowait: assert property (p_nowait)
		else $error("no-wait op froze or held error");

	property p_clear;
		@(posedge ref_clk) disable iff (!rst_b)
		clear_exception && !exc_hit |=> fp_error_out_n && !freeze_hold;
	endproperty
	a_clear: assert property (p_clear)
		else $error("error output held after clear");

	property p_ignore_quiet;
		@(posedge ref_clk) disable iff (!rst_b)
		compat && ign && st_reg.err_n |=> fp_error_out_n;
	endproperty
	a_ignore_quiet: assert property (p_ignore_quiet)
		else $error("error asserted while ignore active");

	property p_ignore_no_freeze;
		@(posedge ref_clk) disable iff (!rst_b)
		ign && !st_reg.frozen |=> !freeze_hold;
	endproperty
	a_ignore_no_freeze: assert property (p_ignore_no_freeze)
		else $error("froze while ignore active");

	property p_release;
		@(posedge ref_clk) disable iff (!rst_b)
		freeze_hold && maskable_interrupt_in_taken && issue_kind == FES_IS_NONE |=> !freeze_hold;
	endproperty
	a_release: assert property (p_release)
		else $error("interrupt did not release freeze");

	// the trap lasts one cycle unless another wait op repeats it
	property p_trap_only;
		@(posedge ref_clk) disable iff (!rst_b)
		!(!compat && issue_kind == FES_IS_WAIT_FP && st_reg.pend && !clear_exception)
			|=> !trap16_req;
	endproperty
	a_trap_only: assert property (p_trap_only)
		else $error("trap raised without a wait op");

	// an asserted error, other than a no-wait pulse, stays out until software clears it
	property p_hold_error;
		@(posedge ref_clk) disable iff (!rst_b)
		compat && !fp_error_out_n && !st_reg.brief && !clear_exception |=> !fp_error_out_n;
	endproperty
	a_hold_error: assert property (p_hold_error)
		else $error("error output dropped without clear");

	// a freeze lasts until the interrupt or a clear
	property p_hold_freeze;
		@(posedge ref_clk) disable iff (!rst_b)
		compat && freeze_hold && !maskable_interrupt_in_taken && !clear_exception |=> freeze_hold;
	endproperty
	a_hold_freeze: assert property (p_hold_freeze)
		else $error("freeze released early");

	// the ignore pin takes two flops to reach the logic
	property p_sync_set;
		@(posedge ref_clk) disable iff (!rst_b)
		s_pin_low_two |=> ign;
	endproperty
	a_sync_set: assert property (p_sync_set)
		else $error("ignore pin not seen after sync");

	// release of the pin reaches the logic the same way
	property p_sync_clear;
		@(posedge ref_clk) disable iff (!rst_b)
		s_pin_high_two |=> !ign;
	endproperty
	a_sync_clear: assert property (p_sync_clear)
		else $error("ignore release not seen after sync");

	// an immediate error held back by ignore comes out once ignore lets go
	property p_ignore_release;
		@(posedge ref_clk) disable iff (!rst_b)
		compat && !ign && st_reg.pend && st_reg.imm && !clear_exception && !exc_hit
			|=> !fp_error_out_n;
	endproperty
	a_ignore_release: assert property (p_ignore_release)
		else $error("held immediate error not reported");

	// no-wait ops never start a freeze
	property p_nowait_no_freeze;
		@(posedge ref_clk) disable iff (!rst_b)
		issue_kind == FES_IS_NO_WAIT && !freeze_hold |=> !freeze_hold;
	endproperty
	a_nowait_no_freeze: assert property (p_nowait_no_freeze)
		else $error("no-wait op froze");

	// under ignore a no-wait op gives no brief pulse either
	property p_ignore_no_pulse;
		@(posedge ref_clk) disable iff (!rst_b)
		compat && ign && issue_kind == FES_IS_NO_WAIT |=> !st_reg.brief;
	endproperty
	a_ignore_no_pulse: assert property (p_ignore_no_pulse)
		else $error("no-wait pulse under ignore");

	// arithmetic faults are always deferred
	property p_arith_deferred;
		@(posedge ref_clk) disable iff (!rst_b)
		exc_hit && exc_in.cls == FES_XC_ARITH |=> st_reg.pend && !st_reg.imm;
	endproperty
	a_arith_deferred: assert property (p_arith_deferred)
		else $error("arithmetic fault not deferred");

	// a precision-only store fault is deferred as well
	property p_precision_deferred;
		@(posedge ref_clk) disable iff (!rst_b)
		exc_hit && exc_in.cls == FES_XC_STORE && exc_in.precision && !exc_in.overflow
			&& !exc_in.underflow && !exc_in.stack_fault && !exc_in.invalid
			&& !exc_in.denormal && !exc_in.zero_divide |=> !st_reg.imm;
	endproperty
	a_precision_deferred: assert property (p_precision_deferred)
		else $error("precision store fault not deferred");

	// an invalid store fault is reported at once
	property p_store_immediate;
		@(posedge ref_clk) disable iff (!rst_b)
		exc_hit && exc_in.cls == FES_XC_STORE && exc_in.invalid |=> st_reg.imm;
	endproperty
	a_store_immediate: assert property (p_store_immediate)
		else $error("store fault not immediate");

	// a pending fault survives until cleared, so a later wait op still freezes
	property p_pend_hold;
		@(posedge ref_clk) disable iff (!rst_b)
		st_reg.pend && !clear_exception |=> st_reg.pend;
	endproperty
	a_pend_hold: assert property (p_pend_hold)
		else $error("pending fault lost");

	// internal mode never shows a freeze or error on the pins
	property p_native_pins;
		@(posedge ref_clk) disable iff (!rst_b)
		!compat |=> fp_error_out_n && !freeze_hold;
	endproperty
	a_native_pins: assert property (p_native_pins)
		else $error("pins active in internal mode");

endmodule : fes_error_signal

/* fes_ext_latch.sv */
// outside request latch and ignore driver facing the error block
// assumes fp_error_out_n is registered on ref_clk; port_access is a one-cycle strobe
`timescale 1ns/1ps
module fes_ext_latch
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic fp_error_out_n,
	input wire logic port_access,
	input wire logic ign_stuck,
	output logic fp_interrupt_request,
	output logic ignore_numeric_error_n
);
	logic err_d;
	logic ign_q;
	////////////////////////////////
	// edge capture, so even a one-cycle no-wait pulse raises a request
	always_ff @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			err_d <= 1'h1;
			fp_interrupt_request <= 1'h0;
			ign_q <= 1'h0;
		end
		else
		begin
			err_d <= fp_error_out_n;
			// a new error edge beats a port access in the same cycle
			if (err_d && !fp_error_out_n)
				fp_interrupt_request <= 1'h1;
			else if (port_access)
				fp_interrupt_request <= 1'h0;
			ign_q <= !fp_error_out_n && (ign_q || port_access);
		end
	end
	// clear from the inverted error output acts at once; stuck is a deliberate misuse
	assign ignore_numeric_error_n = !((ign_q && !fp_error_out_n) || ign_stuck);
endmodule : fes_ext_latch

/* fes_error_signal_tb_top.sv */
// testbench for the error signalling block with the outside latch model
// assumes 10 MHz ref_clk; inputs change on the falling edge
`timescale 1ns/1ps
module fes_error_signal_tb_top
	import fes_pkg::*;
;
	logic ref_clk = 1'h0;
	logic rst_b = 1'h0;
	logic mode = 1'h0;
	fes_exc_t exc = '0;
	fes_issue_kind_t kind = FES_IS_NONE;
	logic clr = 1'h0;
	logic maskable_interrupt_in = 1'h0;
	logic port = 1'h0;
	logic stuck = 1'h0;
	logic err_n, frz, trap, req, ign_n;
	logic [2:0] exp_q[$];
	int n_errors = 0;
	int checked = 0;
	fes_error_signal dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .native_error_mode_select(mode),
		.exc_in(exc), .issue_kind(kind), .clear_exception(clr), .maskable_interrupt_in_taken(maskable_interrupt_in),
		.ignore_numeric_error_n(ign_n), .fp_error_out_n(err_n), .freeze_hold(frz),
		.trap16_req(trap));
	fes_ext_latch latch_u (.ref_clk(ref_clk), .rst_b(rst_b), .fp_error_out_n(err_n),
		.port_access(port), .ign_stuck(stuck), .fp_interrupt_request(req),
		.ignore_numeric_error_n(ign_n));
	////////////////////////////////
	initial
		forever #50 ref_clk = ~ref_clk;
	function automatic fes_exc_t mk(input fes_xclass_t c, input logic [6:0] f);
		return fes_exc_t'({2'b11, c, f});
	endfunction : mk
	task automatic chk(input logic [2:0] got, input logic [2:0] e, input string m);
		checked++;
		if (got !== e)
		begin
			n_errors++;
			$display("[FAIL] %0t %s got %b exp %b", $time, m, got, e);
		end
	endtask : chk
	task automatic close_out();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// drive one cycle of stimulus at the falling edge and note the expected outputs
	task automatic step(input logic [2:0] e, input fes_issue_kind_t k = FES_IS_NONE,
		input fes_exc_t x = '0, input logic [2:0] s = 3'h0);
		kind = k;
		exc = x;
		{clr, maskable_interrupt_in, port} = s;
		exp_q.push_back(e);
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask : step
	// drop every strobe and let n cycles pass
	task automatic idle(input int n);
		kind = FES_IS_NONE;
		exc = '0;
		{clr, maskable_interrupt_in, port} = 3'h0;
		repeat (n) @(negedge ref_clk);
	endtask : idle
	// interrupt, port access, optional fp op under ignore, then clear
	task automatic hnd(input logic hold);
		step(3'b000, FES_IS_NONE, '0, 3'b010);
		chk({2'h0, req}, 3'h1, "request");
		step(3'b000, FES_IS_NONE, '0, 3'b001);
		chk({1'h0, req, ign_n}, 3'h0, "port");
		if (hold)
		begin
			repeat (3) step(3'b000);
			step(3'b000, FES_IS_WAIT_FP);
		end
		step(3'b100, FES_IS_NONE, '0, 3'b100);
		chk({2'h0, ign_n}, 3'h1, "ignore");
		idle(3);
	endtask : hnd
	// scoreboard: compare each noted result one tick after its edge
	initial
		forever
		begin
			@(posedge ref_clk);
			#1;
			if (exp_q.size() > 0)
				chk({err_n, frz, trap}, exp_q.pop_front(), "outputs");
		end
	// watchdog, far beyond the under a hundred cycles the tests need
	initial
	begin
		#(3000 * 100);
		n_errors++;
		close_out();
	end
	initial
	begin
		void'($urandom(75622));
		repeat (16) @(negedge ref_clk);
		rst_b = 1'h1;
		@(negedge ref_clk);
		step(3'b100, FES_IS_NONE, mk(FES_XC_ARITH, 7'($urandom_range(1, 127))));
		step(3'b100, FES_IS_PLAIN);
		step(3'b010, FES_IS_WAIT_FP);
		hnd(1'h1);
		$display("deferred done");
		for (int i = 0; i < 2; i++)
		begin
			step(3'b000, FES_IS_NONE, i ? mk(FES_XC_TRANSC, 7'(1 << $urandom_range(1, 3)))
				: mk(FES_XC_STORE, 7'($urandom_range(1, 63))));
			step(3'b010, FES_IS_WAIT_FP);
			hnd(1'h0);
		end
		$display("immediate done");
		step(3'b100, FES_IS_NONE, mk(FES_XC_ARITH, 7'h40));
		step(3'b000, FES_IS_NO_WAIT);
		step(3'b100);
		step(3'b010, FES_IS_WAIT_FP);
		hnd(1'h0);
		$display("no-wait done");
		stuck = 1'h1;
		repeat (3) @(negedge ref_clk);
		step(3'b100, FES_IS_NONE, mk(FES_XC_STORE, 7'h04));
		step(3'b100, FES_IS_WAIT_FP);
		stuck = 1'h0;
		idle(1);
		for (int w = 0; w < 8 && err_n !== 1'h0; w++)
			@(negedge ref_clk);
		chk({2'h0, err_n}, 3'h0, "release");
		step(3'b010, FES_IS_WAIT_FP);
		hnd(1'h0);
		$display("ignore done");
		mode = 1'h1;
		step(3'b100, FES_IS_NONE, mk(FES_XC_ARITH, 7'h20));
		step(3'b101, FES_IS_WAIT_FP);
		step(3'b100, FES_IS_NONE, mk(FES_XC_STORE, 7'h01));
		step(3'b100, FES_IS_NONE, '0, 3'b100);
		$display("native done");
		close_out();
	end
endmodule : fes_error_signal_tb_top
